//--- verilog/mfra_params.svh
// Offsets, field positions, reset values and sizes of the multifunction request arbiter.
`ifndef MFRA_PARAMS_SVH
`define MFRA_PARAMS_SVH
`define MFRA_OFS_STATUS 5'h00
`define MFRA_OFS_COMMAND 5'h04
`define MFRA_OFS_FNENABLE 5'h08
`define MFRA_OFS_FNNUMBER 5'h0C
`define MFRA_OFS_OUTCOUNT 5'h10
`define MFRA_CMD_RATE_LSB 0
`define MFRA_CMD_RATE_MSB 2
`define MFRA_CMD_SIDEBAND_BIT 8
`define MFRA_CMD_ENABLE_BIT 9
`define MFRA_CMD_DEPTH_LSB 24
`define MFRA_CMD_DEPTH_MSB 31
`define MFRA_CMD_RESET 32'h0000_0001
`define MFRA_FNEN_RESET 4'hF
`define MFRA_FNNUM_RESET 9'h0D1
`define MFRA_FN0_MAX 6'h08
`define MFRA_FN1_MAX 6'h04
`define MFRA_FN2_MAX 6'h04
`define MFRA_FN3_MAX 6'h04
`define MFRA_NUM_FN 4
`define MFRA_NUM_TAGS 32
`define MFRA_TAG_W 5
`endif

//--- verilog/mfra_pkg.sv
// Types shared by the multifunction request arbiter files.
package mfra_pkg;
    typedef enum logic [1:0] {MFRA_BUS_IDLE = 2'b01, MFRA_BUS_RESP = 2'b10} mfra_bus_state_t;
    typedef logic [1:0] mfra_fn_idx_t;
    typedef logic [4:0] mfra_tag_t;
endpackage

//--- verilog/mfra_tag_map.sv
// Small memory that remembers which function owns each outstanding request tag.
`timescale 1ns/10ps
`include "mfra_params.svh"
module mfra_tag_map
    import mfra_pkg::*;
(
    // Clock and enable.
    input wire logic ref_clk,
    input wire logic clkEn,
    // Write side, used when a request is granted.
    input wire logic wrEn,
    input wire mfra_tag_t wrTag,
    input wire mfra_fn_idx_t wrFn,
    // Read side, used when a completion arrives.
    input wire mfra_tag_t rdTag,
    output mfra_fn_idx_t rdFn_reg
);
    mfra_fn_idx_t mem [`MFRA_NUM_TAGS];

    // Read data come from a register so the lookup lands one cycle after the completion.
    always_ff @(posedge ref_clk)
    begin
        if (clkEn)
        begin
            if (wrEn)
                mem[wrTag] <= wrFn;
            rdFn_reg <= mem[rdTag];
        end
    end
endmodule

//--- verilog/mfra_arbiter.sv
// Multifunction request arbiter: shared request front end for several port functions.
`timescale 1ns/10ps
`include "mfra_params.svh"
// Contract
// - While the shared enable bit 9 of the command register is zero no new request is presented.
// - That one enable gates every function, and per-function enables live in their own register.
// - Functions other than function 0 may carry any number from 1 to 7, not necessarily in order.
// - An internal arbiter picks the next request from any function and one common path issues it.
// - Toward the corelogic the master looks like one agent with one request stream.
// - Completions are accepted in any order, matched by tag rather than by issue sequence.
// - The design is free of deadlock, balancing slots so one function cannot starve another.
// - Outstanding requests over all functions never exceed the programmed queue depth.
// - All functions share one rate and one request path, which cannot change while enabled.
// - The advertised outstanding maximum equals the sum of every function's own maximum.
module mfra_arbiter
    import mfra_pkg::*;
(
    // Clock, clock enable and asynchronous active-low reset.
    input wire logic ref_clk,
    input wire logic clkEn,
    input wire logic reset_n,
    // Avalon-MM register slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Request side of the internal functions.
    input wire logic [3:0] fnReqValid,
    input wire logic [3:0][31:0] fnReqAddr,
    input wire logic [3:0] fnReqRead,
    output logic [3:0] fnReqReady,
    input wire logic [3:0] fnBufFull,
    // Completions handed back to the functions.
    output logic [3:0] cplFnValid,
    output mfra_tag_t cplFnTag,
    // Common request path toward the corelogic.
    output logic reqValid,
    output logic [31:0] reqAddr,
    output logic reqRead,
    output mfra_tag_t reqTag,
    input wire logic reqReady,
    input wire logic cplValid,
    input wire mfra_tag_t cplTag,
    output logic readBufFull_n,
    // Shared transfer mode.
    output logic [2:0] rateSel,
    output logic sidebandSel
);
    // Byte-lane merge used by every writable register.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                res[b*8 +: 8] = wd[b*8 +: 8];
        return res;
    endfunction

    // Per-function slot quota.
    function automatic logic [5:0] fnMax(input int idx);
        case (idx)
            0: fnMax = `MFRA_FN0_MAX;
            1: fnMax = `MFRA_FN1_MAX;
            2: fnMax = `MFRA_FN2_MAX;
            default: fnMax = `MFRA_FN3_MAX;
        endcase
    endfunction

    // Round-robin pick: the first eligible function after the last one granted.
    function automatic logic [3:0] rrPick(input logic [3:0] elig, input mfra_fn_idx_t last);
        logic [3:0] res;
        mfra_fn_idx_t idx;
        res = 4'h0;
        for (int k = 4; k > 0; k--)
        begin
            idx = last + 2'(k);
            if (elig[idx])
                res = 4'h0 | (4'h1 << idx);
        end
        return res;
    endfunction

    // The advertised maximum is the sum of the quotas; the tag pool is sized to cover it.
    localparam logic [7:0] ADV_MAX = 8'(`MFRA_FN0_MAX + `MFRA_FN1_MAX + `MFRA_FN2_MAX
                                        + `MFRA_FN3_MAX);

    // Reset release through two flip-flops.
    logic rstSync1, rstN;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstSync1 <= 1'b0;
            rstN <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstN <= rstSync1;
        end
    end

    // Register file and bus slave state.
    mfra_bus_state_t bus_reg, bus_next;
    logic [31:0] cmd_reg, cmd_next, rd_reg, rd_next;
    logic [3:0] fnEn_reg, fnEn_next;
    logic [8:0] fnNum_reg, fnNum_next;
    logic [5:0] outCount_reg;
    logic portEnable;
    logic [8:0] depth;
    logic [31:0] wm;
    assign portEnable = cmd_reg[`MFRA_CMD_ENABLE_BIT];
    assign depth = {1'b0, cmd_reg[`MFRA_CMD_DEPTH_MSB:`MFRA_CMD_DEPTH_LSB]} + 9'h001;
    assign rateSel = cmd_reg[`MFRA_CMD_RATE_MSB:`MFRA_CMD_RATE_LSB];
    assign sidebandSel = cmd_reg[`MFRA_CMD_SIDEBAND_BIT];
    assign avs_readdata = rd_reg;
    // Waitrequest drops only in the answer cycle, and never while the block is frozen.
    assign avs_waitrequest = (avs_read | avs_write) & ~(bus_reg == MFRA_BUS_RESP & clkEn);

    // Bus decode: read data are captured in the idle cycle, writes land in the answer cycle.
    always_comb
    begin
        bus_next = bus_reg;
        cmd_next = cmd_reg;
        fnEn_next = fnEn_reg;
        fnNum_next = fnNum_reg;
        rd_next = rd_reg;
        wm = 32'h0000_0000;
        case (bus_reg)
            MFRA_BUS_IDLE:
            begin
                if (avs_read | avs_write)
                    bus_next = MFRA_BUS_RESP;
                case (avs_address)
                    `MFRA_OFS_STATUS: rd_next = {24'h00_0000, ADV_MAX};
                    `MFRA_OFS_COMMAND: rd_next = cmd_reg;
                    `MFRA_OFS_FNENABLE: rd_next = {28'h000_0000, fnEn_reg};
                    `MFRA_OFS_FNNUMBER: rd_next = {23'h00_0000, fnNum_reg};
                    `MFRA_OFS_OUTCOUNT: rd_next = {26'h000_0000, outCount_reg};
                    default: rd_next = 32'h0000_0000;
                endcase
            end
            MFRA_BUS_RESP:
            begin
                bus_next = MFRA_BUS_IDLE;
                if (avs_write)
                begin
                    case (avs_address)
                        `MFRA_OFS_COMMAND:
                        begin
                            wm = mergeBytes(cmd_reg, avs_writedata, avs_byteenable);
                            cmd_next = wm;
                            // Rate and path are frozen while the port is enabled.
                            if (portEnable)
                            begin
                                cmd_next[`MFRA_CMD_RATE_MSB:`MFRA_CMD_RATE_LSB] = rateSel;
                                cmd_next[`MFRA_CMD_SIDEBAND_BIT] = sidebandSel;
                            end
                        end
                        `MFRA_OFS_FNENABLE:
                        begin
                            wm = mergeBytes({28'h000_0000, fnEn_reg}, avs_writedata,
                                            avs_byteenable);
                            fnEn_next = wm[3:0];
                        end
                        `MFRA_OFS_FNNUMBER:
                        begin
                            wm = mergeBytes({23'h00_0000, fnNum_reg}, avs_writedata,
                                            avs_byteenable);
                            // A number of zero is refused: only function 0 may hold it.
                            for (int s = 0; s < 3; s++)
                                if (wm[s*3 +: 3] != 3'h0)
                                    fnNum_next[s*3 +: 3] = wm[s*3 +: 3];
                        end
                        default: wm = 32'h0000_0000;
                    endcase
                end
            end
            default: bus_next = MFRA_BUS_IDLE;
        endcase
    end

    // Bus register stage.
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            bus_reg <= MFRA_BUS_IDLE;
            cmd_reg <= `MFRA_CMD_RESET;
            fnEn_reg <= `MFRA_FNEN_RESET;
            fnNum_reg <= `MFRA_FNNUM_RESET;
            rd_reg <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            bus_reg <= bus_next;
            cmd_reg <= cmd_next;
            fnEn_reg <= fnEn_next;
            fnNum_reg <= fnNum_next;
            rd_reg <= rd_next;
        end
    end

    // Arbiter and tracking state.
    logic [31:0] inUse_reg, inUse_next;
    logic [5:0] outCount_next;
    logic [3:0][5:0] fnCount_reg, fnCount_next;
    mfra_fn_idx_t last_reg, last_next;
    logic reqValid_next, reqRead_next, cplPend_reg, cplPend_next, rbf_next;
    logic [31:0] reqAddr_next;
    mfra_tag_t reqTag_next, freeTag, cplFnTag_next, cplTagD;
    logic [3:0] elig, grant, cplFnValid_next;
    logic freeAvail, stageFree, canIssue, cplOk;
    mfra_fn_idx_t grantIdx, lookFn;

    // Completion owner lookup, one cycle behind the completion.
    mfra_tag_map tagMap (
        .ref_clk(ref_clk),
        .clkEn(clkEn),
        .wrEn(|grant),
        .wrTag(freeTag),
        .wrFn(grantIdx),
        .rdTag(cplTag),
        .rdFn_reg(lookFn)
    );

    // Pick a free tag, gate eligibility, and grant one function per cycle.
    always_comb
    begin
        freeTag = 5'h00;
        freeAvail = 1'b0;
        for (int t = `MFRA_NUM_TAGS - 1; t >= 0; t--)
            if (!inUse_reg[t])
            begin
                freeTag = 5'(t);
                freeAvail = 1'b1;
            end
        // A function at its own quota waits, so it cannot crowd out the others.
        for (int f = 0; f < `MFRA_NUM_FN; f++)
            elig[f] = fnReqValid[f] & fnEn_reg[f] & (fnCount_reg[f] < fnMax(f));
        stageFree = ~reqValid | reqReady;
        canIssue = portEnable & stageFree & freeAvail & ({3'h0, outCount_reg} < depth);
        grant = canIssue ? rrPick(elig, last_reg) : 4'h0;
        grantIdx = 2'h0;
        for (int f = 0; f < `MFRA_NUM_FN; f++)
            if (grant[f])
                grantIdx = 2'(f);
        cplOk = cplValid & inUse_reg[cplTag];
        inUse_next = inUse_reg;
        if (cplOk)
            inUse_next[cplTag] = 1'b0;
        if (|grant)
            inUse_next[freeTag] = 1'b1;
        outCount_next = outCount_reg + 6'(|grant) - 6'(cplOk);
        fnCount_next = fnCount_reg;
        if (|grant)
            fnCount_next[grantIdx] = fnCount_next[grantIdx] + 6'h01;
        if (cplPend_reg)
            fnCount_next[lookFn] = fnCount_next[lookFn] - 6'h01;
        last_next = (|grant) ? grantIdx : last_reg;
        // One common stage presents the winner, whichever function it came from.
        reqValid_next = (|grant) | (reqValid & ~reqReady);
        reqAddr_next = (|grant) ? fnReqAddr[grantIdx] : reqAddr;
        reqRead_next = (|grant) ? fnReqRead[grantIdx] : reqRead;
        reqTag_next = (|grant) ? freeTag : reqTag;
        cplPend_next = cplOk;
        cplFnValid_next = cplPend_reg ? (4'h1 << lookFn) : 4'h0;
        cplFnTag_next = cplPend_reg ? cplTagD : cplFnTag;
        // Throttle read return only while a full function still has data due.
        rbf_next = 1'b1;
        for (int f = 0; f < `MFRA_NUM_FN; f++)
            if (fnBufFull[f] && fnCount_reg[f] != 6'h00)
                rbf_next = 1'b0;
    end
    // A frozen block grants nothing, so no function believes its request was taken.
    assign fnReqReady = clkEn ? grant : 4'h0;

    // Arbiter register stage.
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            inUse_reg <= 32'h0000_0000;
            outCount_reg <= 6'h00;
            fnCount_reg <= '0;
            last_reg <= 2'h3;
            reqValid <= 1'b0;
            reqAddr <= 32'h0000_0000;
            reqRead <= 1'b0;
            reqTag <= 5'h00;
            cplPend_reg <= 1'b0;
            cplTagD <= 5'h00;
            cplFnValid <= 4'h0;
            cplFnTag <= 5'h00;
            readBufFull_n <= 1'b1;
        end
        else if (clkEn)
        begin
            inUse_reg <= inUse_next;
            outCount_reg <= outCount_next;
            fnCount_reg <= fnCount_next;
            last_reg <= last_next;
            reqValid <= reqValid_next;
            reqAddr <= reqAddr_next;
            reqRead <= reqRead_next;
            reqTag <= reqTag_next;
            cplPend_reg <= cplPend_next;
            cplTagD <= cplTag;
            cplFnValid <= cplFnValid_next;
            cplFnTag <= cplFnTag_next;
            readBufFull_n <= rbf_next;
        end
    end

    // Checks on the arbiter.
    enable_gate_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        !portEnable && !reqValid |=> !reqValid)
        else $error("New request presented while the port is disabled.");
    depth_limit_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        outCount_reg > $past(outCount_reg) |-> {3'h0, outCount_reg} <= $past(depth))
        else $error("Outstanding count above programmed depth.");
    grant_onehot_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        $onehot0(grant) && (grant & ~fnEn_reg) == 4'h0)
        else $error("Grant not one-hot or given to a disabled function.");
    rr_advance_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        clkEn && |grant && !grant[last_reg] |=> last_reg != $past(last_reg))
        else $error("Round-robin pointer did not move after a grant.");
    stage_hold_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        reqValid && !reqReady |=> reqValid && $stable(reqTag) && $stable(reqAddr))
        else $error("Presented request changed before acceptance.");
    tag_fresh_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        clkEn && |grant |-> !inUse_reg[freeTag] ##1 inUse_reg[reqTag])
        else $error("Granted tag was already in use.");
    quota_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        fnCount_reg[0] <= `MFRA_FN0_MAX && fnCount_reg[1] <= `MFRA_FN1_MAX)
        else $error("Function exceeded its slot quota.");
    rate_lock_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        portEnable && $past(portEnable) |-> $stable(rateSel) && $stable(sidebandSel))
        else $error("Rate or path changed while enabled.");
    fn_number_a: assert property (@(posedge ref_clk) disable iff (!rstN)
        fnNum_reg[2:0] != 3'h0 && fnNum_reg[5:3] != 3'h0 && fnNum_reg[8:6] != 3'h0)
        else $error("Secondary function numbered zero.");
endmodule

//--- testbench/mfra_corelogic_model.sv
// Behavioural corelogic target that accepts requests and completes them out of order.
`timescale 1ns/10ps
module mfra_corelogic_model
    import mfra_pkg::*;
(
    // Clock, reset and scenario controls.
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic holdCpl,
    input wire logic slowReady,
    // Request path from the master.
    input wire logic reqValid,
    input wire logic reqRead,
    input wire mfra_tag_t reqTag,
    output logic reqReady,
    // Completions and read-return throttle.
    output logic cplValid,
    output mfra_tag_t cplTag,
    input wire logic readBufFull_n
);
    mfra_tag_t pendTag[$];
    logic pendRd[$];
    integer seed = 32'h0000_51C3;
    int idx;

    // A random pending tag completes, so the master cannot count on issue order.
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reqReady <= 1'b0;
            cplValid <= 1'b0;
            cplTag <= 5'h00;
            pendTag.delete();
            pendRd.delete();
        end
        else
        begin
            if (reqValid && reqReady)
            begin
                pendTag.push_back(reqTag);
                pendRd.push_back(reqRead);
            end
            reqReady <= slowReady ? 1'($random(seed)) : 1'b1;
            cplValid <= 1'b0;
            // Idle tag lines toggle so a stale tag is never mistaken for a live one.
            cplTag <= ~cplTag;
            idx = (pendTag.size() > 0) ? int'($unsigned($random(seed)) % pendTag.size()) : 0;
            // No read data at all while throttled, which also holds back later reads.
            if (!holdCpl && pendTag.size() > 0 && !(pendRd[idx] && !readBufFull_n) &&
                $unsigned($random(seed)) % 3 == 0)
            begin
                cplValid <= 1'b1;
                cplTag <= pendTag[idx];
                pendTag.delete(idx);
                pendRd.delete(idx);
            end
        end
    end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the multifunction request arbiter with a corelogic model.
`timescale 1ns/10ps
`include "mfra_params.svh"
module tb
    import mfra_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] fnReqValid = 4'h0;
    logic [3:0][31:0] fnReqAddr = '0;
    logic [3:0] fnReqRead = 4'h0;
    logic [3:0] fnBufFull = 4'h0;
    logic [3:0] fnReqReady, cplFnValid;
    mfra_tag_t cplFnTag, reqTag, cplTag, tag1, tag2;
    logic reqValid, reqRead, reqReady, cplValid, readBufFull_n, sidebandSel;
    logic [31:0] reqAddr, rd;
    logic [2:0] rateSel;
    logic holdCpl = 1'b0;
    logic slowReady = 1'b0;
    logic [3:0] exp1 = 4'h0;
    logic [3:0] exp2 = 4'h0;
    logic [3:0] busy;
    logic expRbf = 1'b1;
    logic clkEn = 1'b1;
    int fnOut[4];
    logic [34:0] reqQ[$];
    logic [34:0] ent;
    int grantLog[$];
    mfra_fn_idx_t owner[32];
    integer seed = 32'h2273;
    int failures = 0;
    int checked = 0;
    int outCnt = 0;
    int depthSet = 1;
    int n;

    // The clock toggles every half period of 2 ns.
    always #2 ref_clk = ~ref_clk;

    mfra_arbiter u_dut (.ref_clk(ref_clk), .clkEn(clkEn), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fnReqValid(fnReqValid), .fnReqAddr(fnReqAddr),
        .fnReqRead(fnReqRead), .fnReqReady(fnReqReady), .fnBufFull(fnBufFull),
        .cplFnValid(cplFnValid), .cplFnTag(cplFnTag), .reqValid(reqValid), .reqAddr(reqAddr),
        .reqRead(reqRead), .reqTag(reqTag), .reqReady(reqReady), .cplValid(cplValid),
        .cplTag(cplTag), .readBufFull_n(readBufFull_n), .rateSel(rateSel),
        .sidebandSel(sidebandSel));

    mfra_corelogic_model u_core (.ref_clk(ref_clk), .reset_n(reset_n), .holdCpl(holdCpl),
        .slowReady(slowReady), .reqValid(reqValid), .reqRead(reqRead), .reqTag(reqTag),
        .reqReady(reqReady), .cplValid(cplValid), .cplTag(cplTag),
        .readBufFull_n(readBufFull_n));

    // Prints the verdict and ends the run.
    task automatic conclude();
    begin
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    end
    endtask

    // One register access, held until waitrequest is low at a rising edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] data);
        int k;
    begin
        k = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            k = k + 1;
            if (k > 50)
            begin
                failures = failures + 1;
                conclude();
            end
            @(posedge ref_clk);
        end
        data = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    end
    endtask

    // Advertised maximum is the sum of every function's own maximum.
    function automatic logic [31:0] sumMax();
        sumMax = 32'(`MFRA_FN0_MAX + `MFRA_FN1_MAX + `MFRA_FN2_MAX + `MFRA_FN3_MAX);
    endfunction

    // Command word with the interface enabled.
    function automatic logic [31:0] cmdWord(input int depth, input logic [2:0] rate,
                                            input logic side);
        cmdWord = {8'(depth - 1), 14'h0000, 1'b1, side, 5'h00, rate};
    endfunction

    // Watches grants, issued requests and completions on every edge.
    always @(posedge ref_clk)
    begin
        if (reset_n)
        begin
            if (reqValid && reqReady && reqQ.size() > 0)
            begin
                ent = reqQ.pop_front();
                chk("reqAddr", ent[31:0], reqAddr);
                chk("reqRead", {31'h0, ent[34]}, {31'h0, reqRead});
                owner[reqTag] = ent[33:32];
                outCnt = outCnt + 1;
            end
            chk("oneGrant", 32'h1, {31'h0, $countones(fnReqValid & fnReqReady) <= 1});
            // Throttle is due while a full function still owes data.
            chk("readBufFull_n", {31'h0, expRbf}, {31'h0, readBufFull_n});
            for (int k = 0; k < 4; k++)
                busy[k] = fnOut[k] != 0;
            expRbf <= ~|(fnBufFull & busy);
            for (int k = 0; k < 4; k++)
            begin
                if (fnReqValid[k] && fnReqReady[k])
                begin
                    grantLog.push_back(k);
                    reqQ.push_back({fnReqRead[k], 2'(k), fnReqAddr[k]});
                    fnOut[k] = fnOut[k] + 1;
                end
                // A function's slot frees one cycle after its completion arrives.
                if (exp1[k])
                    fnOut[k] = fnOut[k] - 1;
            end
            exp1 <= 4'h0;
            if (cplValid)
            begin
                exp1 <= 4'h1 << owner[cplTag];
                outCnt = outCnt - 1;
            end
            tag1 <= cplTag;
            exp2 <= exp1;
            tag2 <= tag1;
            chk("cplFnValid", {28'h0, exp2}, {28'h0, cplFnValid});
            if (exp2 != 4'h0)
                chk("cplFnTag", {27'h0, tag2}, {27'h0, cplFnTag});
            chk("withinDepth", 32'h1, {31'h0, outCnt <= depthSet});
        end
    end

    // A hang is cut short here.
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        failures = failures + 1;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        bus(1'b0, `MFRA_OFS_STATUS, 32'h0, rd);
        chk("advertisedMax", sumMax(), {24'h0, rd[7:0]});
        bus(1'b0, `MFRA_OFS_COMMAND, 32'h0, rd);
        chk("command", `MFRA_CMD_RESET, rd);
        bus(1'b1, 5'h14, 32'hFFFF_FFFF, rd);
        bus(1'b0, 5'h14, 32'h0, rd);
        chk("unmapped", 32'h0000_0000, rd);
        bus(1'b0, `MFRA_OFS_FNNUMBER, 32'h0, rd);
        chk("fnNumber", {23'h0, `MFRA_FNNUM_RESET}, {23'h0, rd[8:0]});
        bus(1'b1, `MFRA_OFS_FNNUMBER, 32'h0000_012F, rd);
        bus(1'b1, `MFRA_OFS_FNNUMBER, 32'h0000_0128, rd);
        bus(1'b0, `MFRA_OFS_FNNUMBER, 32'h0, rd);
        chk("fnNumber", 32'h0000_012F, {23'h0, rd[8:0]});
        // Every function asks while the shared enable is still clear.
        fnReqValid <= 4'hF;
        holdCpl <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk("grantsOff", 32'h0, grantLog.size());
        bus(1'b1, `MFRA_OFS_FNENABLE, 32'h0000_000B, rd);
        depthSet = 3;
        bus(1'b1, `MFRA_OFS_COMMAND, cmdWord(3, 3'h2, 1'b1), rd);
        repeat (30) @(posedge ref_clk);
        chk("outstanding", 32'h3, outCnt);
        chk("grantCount", 32'h3, grantLog.size());
        chk("grant0", 32'h0, grantLog[0]);
        chk("grant1", 32'h1, grantLog[1]);
        chk("grant2", 32'h3, grantLog[2]);
        chk("rateSel", 32'h2, {29'h0, rateSel});
        chk("sidebandSel", 32'h1, {31'h0, sidebandSel});
        // Mode bits must not move while enabled; a depth below the quota sum keeps the limit live.
        holdCpl <= 1'b0;
        depthSet = 6;
        bus(1'b1, `MFRA_OFS_COMMAND, cmdWord(6, 3'h4, 1'b0), rd);
        chk("rateSel", 32'h2, {29'h0, rateSel});
        chk("sidebandSel", 32'h1, {31'h0, sidebandSel});
        bus(1'b1, `MFRA_OFS_FNENABLE, 32'h0000_000F, rd);
        slowReady <= 1'b1;
        repeat (3000)
        begin
            @(posedge ref_clk);
            fnReqValid <= 4'($random(seed));
            fnReqRead <= 4'($random(seed));
            fnReqAddr <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            fnBufFull <= (($random(seed) & 7) == 0) ? 4'($random(seed)) : 4'h0;
        end
        @(posedge ref_clk);
        fnReqValid <= 4'h0;
        fnBufFull <= 4'h0;
        slowReady <= 1'b0;
        // Let a request still in the stage reach the corelogic before draining.
        repeat (3) @(posedge ref_clk);
        n = 0;
        while (outCnt != 0 && n < 1000)
        begin
            @(posedge ref_clk);
            n = n + 1;
        end
        chk("drained", 32'h0, outCnt);
        chk("progress", 32'h1, {31'h0, grantLog.size() > 200});
        repeat (4) @(posedge ref_clk);
        bus(1'b0, `MFRA_OFS_OUTCOUNT, 32'h0, rd);
        chk("outCountReg", 32'h0, rd);
        // A frozen block takes no request even though one is waiting.
        n = grantLog.size();
        clkEn <= 1'b0;
        fnReqValid <= 4'h4;
        repeat (10) @(posedge ref_clk);
        chk("frozenGrants", n, grantLog.size());
        chk("frozenReq", 32'h0, {31'h0, reqValid});
        clkEn <= 1'b1;
        fnReqValid <= 4'h0;
        @(posedge ref_clk);
        conclude();
    end
endmodule
